/* rtl/pwt_pkg.sv */
// constants, register map and types of the trip-protected pwm generator
// assumes a single pclk domain and an apb slave with 32-bit data
package pwt_pkg;
	localparam int NCH = 3;
	localparam int NZONE = 3;
	localparam int CW = 16;
	localparam int DBW = 8;
	localparam int DIVW = 8;
	// byte addresses of the registers
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_DEADBAND = 8'h08;
	localparam logic [7:0] ADDR_DIV = 8'h0c;
	localparam logic [7:0] ADDR_ZONEMAP = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_MOD0 = 8'h20;
	localparam logic [7:0] ADDR_PHASE0 = 8'h30;
	localparam logic [7:0] ADDR_STRIDE = 8'h04;
	// ctrl fields
	localparam int CTRL_SHAPE = 0;
	localparam int CTRL_POL = 1;
	localparam int CTRL_FLOAT = 2;
	localparam int CTRL_SYNC = 3;
	localparam int CTRL_ADCSEL = 5;
	localparam int CTRL_TASKSEL = 7;
	localparam int CTRL_TZMODE = 9;
	localparam int CTRL_W = 15;
	// div fields
	localparam int DIV_ADC = 0;
	localparam int DIV_TASK = 8;
	// status fields
	localparam int ST_ONESHOT = 0;
	localparam int ST_CBC = 3;
	localparam int ST_PSON = 6;
	localparam int ST_CNT = 16;
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0002;
	localparam logic [CW-1:0] PERIOD_RST = 16'h03e8;
	localparam logic [DBW-1:0] DEADBAND_RST = 8'h00;
	localparam logic [DIVW-1:0] DIV_RST = 8'h01;
	localparam logic [3*NCH-1:0] ZONEMAP_RST = 9'h000;
	localparam logic [CW-1:0] CNT_ONE = 16'h0001;
	localparam logic [DIVW-1:0] DIV_ONE = 8'h01;
	localparam logic [DBW-1:0] DB_ONE = 8'h01;
	// carrier shapes, trip actions, sync sources, event selections
	typedef enum logic {SHAPE_SAW, SHAPE_TRI} pwt_shape_e;
	typedef enum logic [1:0] {TZ_NONE, TZ_ONESHOT, TZ_CBC, TZ_RSVD} pwt_tzmode_e;
	typedef enum logic [1:0] {SYNC_SELF, SYNC_GROUP, SYNC_EXT, SYNC_OFF} pwt_sync_e;
	localparam logic [1:0] EV_UNDER = 2'h1;
	localparam logic [1:0] EV_OVER = 2'h2;
	typedef enum {PS_OFF, PS_ON} pwt_ps_e;
endpackage

/* rtl/pwt_top.sv */
// three-channel complementary pwm with trip zones and power-stage control
// assumes apb master on pclk; all pins synchronous to pclk
//
// Chosen here: the address map and the APB slave port.
module pwt_top import pwt_pkg::*; #(
	parameter bit PROT_EN = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// trip zones, active low
	input wire logic trip_zone_one,
	input wire logic trip_zone_two,
	input wire logic trip_zone_three,
	// power stage
	input wire logic ps_enable_in,
	output logic ps_enabled,
	output logic ps_enable_n,
	// synchronisation
	input wire logic sync_in,
	input wire logic ext_sync_pin,
	output logic sync_out,
	// triggers
	output logic adc_soc,
	output logic task_trig,
	// pwm pins with output enables
	output logic [NCH-1:0] pwm_out_primary,
	output logic [NCH-1:0] pwm_out_primary_oe,
	output logic [NCH-1:0] pwm_out_complement,
	output logic [NCH-1:0] pwm_out_complement_oe
);

	function automatic logic ev_hit(input logic [1:0] sel, input logic und, input logic ovf);
		ev_hit = (sel[0] & und) | (sel[1] & ovf);
	endfunction

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] base, input int idx);
		is_addr = (a == base + 8'(idx) * ADDR_STRIDE);
	endfunction

	logic [CTRL_W-1:0] ctrl_r;
	logic [CW-1:0] period_r;
	logic [DBW-1:0] deadband_r;
	logic [DIVW-1:0] adc_div_r;
	logic [DIVW-1:0] task_div_r;
	logic [3*NCH-1:0] zonemap_r;
	logic [CW-1:0] mod_r [NCH];
	logic [CW-1:0] phase_r [NCH];
	logic [CW-1:0] cnt_r [NCH];
	logic [NCH-1:0] dir_down_r;
	logic [NCH-1:0] und_w;
	logic [NCH-1:0] ovf_w;
	logic [NZONE-1:0] osht_r;
	logic [NZONE-1:0] cbc_r;
	logic [NZONE-1:0] osht_nxt;
	logic [NZONE-1:0] cbc_nxt;
	logic [NZONE-1:0] trip_w;
	logic [NZONE-1:0] osht_clr_w;
	logic [NCH-1:0] force_w;
	logic [NCH-1:0] raw_a_r;
	logic [DBW-1:0] db_cnt_r [NCH];
	logic [DIVW-1:0] adc_cnt_r;
	logic [DIVW-1:0] task_cnt_r;
	logic ext_prev_r;
	logic ena_prev_r;
	logic sync_w;
	logic wr_w;
	logic rd_w;
	logic hit_w;
	logic [31:0] rdata_w;
	logic [31:0] status_w;
	pwt_ps_e ps_r;
	pwt_ps_e ps_nxt;
	pwt_shape_e shape_w;
	pwt_sync_e sync_src_w;

	assign shape_w = pwt_shape_e'(ctrl_r[CTRL_SHAPE]);
	assign sync_src_w = pwt_sync_e'(ctrl_r[CTRL_SYNC +: 2]);

	// apb: answer in the second access cycle, write lands on that edge
	assign wr_w = psel & penable & pready & pwrite;
	assign rd_w = psel & penable & ~pready;

	always_comb begin
		status_w = '0;
		status_w[ST_ONESHOT +: NZONE] = osht_r;
		status_w[ST_CBC +: NZONE] = cbc_r;
		status_w[ST_PSON] = (ps_r == PS_ON);
		status_w[ST_CNT +: CW] = cnt_r[0];
	end

	always_comb begin
		rdata_w = '0;
		hit_w = 1'b1;
		case (paddr)
			ADDR_CTRL: rdata_w[CTRL_W-1:0] = ctrl_r;
			ADDR_PERIOD: rdata_w[CW-1:0] = period_r;
			ADDR_DEADBAND: rdata_w[DBW-1:0] = deadband_r;
			ADDR_DIV: rdata_w = {16'h0000, task_div_r, adc_div_r};
			ADDR_ZONEMAP: rdata_w[3*NCH-1:0] = zonemap_r;
			ADDR_STATUS: rdata_w = status_w;
			default: hit_w = 1'b0;
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (is_addr(paddr, ADDR_MOD0, i)) begin
				rdata_w[CW-1:0] = mod_r[i];
				hit_w = 1'b1;
			end
			if (is_addr(paddr, ADDR_PHASE0, i)) begin
				rdata_w[CW-1:0] = phase_r[i];
				hit_w = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= rd_w;
			pslverr <= rd_w & ~hit_w;
			prdata <= (rd_w & hit_w & ~pwrite) ? rdata_w : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			period_r <= PERIOD_RST;
			deadband_r <= DEADBAND_RST;
			adc_div_r <= DIV_RST;
			task_div_r <= DIV_RST;
			zonemap_r <= ZONEMAP_RST;
		end else if (wr_w) begin
			case (paddr)
				ADDR_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
				ADDR_PERIOD: period_r <= (pwdata[CW-1:0] == '0) ? CNT_ONE : pwdata[CW-1:0];
				ADDR_DEADBAND: deadband_r <= pwdata[DBW-1:0];
				ADDR_DIV: begin
					adc_div_r <= pwdata[DIV_ADC +: DIVW];
					task_div_r <= pwdata[DIV_TASK +: DIVW];
				end
				ADDR_ZONEMAP: zonemap_r <= pwdata[3*NCH-1:0];
				default: ;
			endcase
		end
	end

	// one-shot latches cleared by writing one to status
	generate
		for (genvar z = 0; z < NZONE; z++) begin : g_oclr
			assign osht_clr_w[z] = wr_w & (paddr == ADDR_STATUS) & pwdata[ST_ONESHOT + z];
		end
	endgenerate

	// sync source selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_sync_pin;
		end
	end

	always_comb begin
		case (sync_src_w)
			SYNC_SELF: sync_w = und_w[0];
			SYNC_GROUP: sync_w = sync_in;
			SYNC_EXT: sync_w = ext_sync_pin & ~ext_prev_r;
			default: sync_w = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= 1'b0;
		end else begin
			sync_out <= sync_w;
		end
	end

	// carriers, comparators and dead band per channel
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			logic load_w;
			logic [CW-1:0] ph_w;
			logic act_w;
			logic raw_w;

			// channel zero is master; master ignores phase under self sync
			assign load_w = sync_w & ((c != 0) | (sync_src_w != SYNC_SELF));
			// phase is limited to one period
			assign ph_w = (phase_r[c] > period_r) ? period_r : phase_r[c];
			assign und_w[c] = (cnt_r[c] == '0);
			assign ovf_w[c] = (shape_w == SHAPE_TRI) ? (cnt_r[c] == period_r) :
				(cnt_r[c] == period_r - CNT_ONE);
			assign act_w = mod_r[c] > cnt_r[c];
			assign raw_w = act_w ? ctrl_r[CTRL_POL] : ~ctrl_r[CTRL_POL];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mod_r[c] <= '0;
					phase_r[c] <= '0;
				end else if (wr_w) begin
					if (is_addr(paddr, ADDR_MOD0, c)) begin
						mod_r[c] <= pwdata[CW-1:0];
					end
					if (is_addr(paddr, ADDR_PHASE0, c)) begin
						phase_r[c] <= pwdata[CW-1:0];
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_r[c] <= '0;
					dir_down_r[c] <= 1'b0;
				end else if (load_w) begin
					cnt_r[c] <= ph_w;
					dir_down_r[c] <= 1'b0;
				end else if (shape_w == SHAPE_SAW) begin
					cnt_r[c] <= (cnt_r[c] >= period_r - CNT_ONE) ? '0 : cnt_r[c] + CNT_ONE;
					dir_down_r[c] <= 1'b0;
				end else if (dir_down_r[c]) begin
					if (cnt_r[c] <= CNT_ONE) begin
						dir_down_r[c] <= 1'b0;
					end
					cnt_r[c] <= (cnt_r[c] == '0) ? CNT_ONE : cnt_r[c] - CNT_ONE;
				end else begin
					if (cnt_r[c] + CNT_ONE >= period_r) begin
						dir_down_r[c] <= 1'b1;
					end
					cnt_r[c] <= (cnt_r[c] >= period_r) ? period_r - CNT_ONE : cnt_r[c] + CNT_ONE;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					raw_a_r[c] <= 1'b0;
					db_cnt_r[c] <= '0;
				end else begin
					raw_a_r[c] <= raw_w;
					if (raw_w != raw_a_r[c]) begin
						db_cnt_r[c] <= deadband_r;
					end else if (db_cnt_r[c] != '0) begin
						db_cnt_r[c] <= db_cnt_r[c] - DB_ONE;
					end
				end
			end

			// force only from zones mapped to this channel; power stage off
			assign force_w[c] = PROT_EN & ((ps_nxt == PS_OFF) |
				(|(zonemap_r[3*c +: 3] & (osht_nxt | cbc_nxt))));

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pwm_out_primary[c] <= 1'b0;
					pwm_out_complement[c] <= 1'b0;
					pwm_out_primary_oe[c] <= ~CTRL_RST[CTRL_FLOAT];
					pwm_out_complement_oe[c] <= ~CTRL_RST[CTRL_FLOAT];
				end else if (force_w[c]) begin
					pwm_out_primary[c] <= 1'b0;
					pwm_out_complement[c] <= 1'b0;
					pwm_out_primary_oe[c] <= ~ctrl_r[CTRL_FLOAT];
					pwm_out_complement_oe[c] <= ~ctrl_r[CTRL_FLOAT];
				end else begin
					// edge delayed while the dead band runs, both low meanwhile
					pwm_out_primary[c] <= raw_a_r[c] & (db_cnt_r[c] == '0);
					pwm_out_complement[c] <= ~raw_a_r[c] & (db_cnt_r[c] == '0);
					pwm_out_primary_oe[c] <= 1'b1;
					pwm_out_complement_oe[c] <= 1'b1;
				end
			end
		end
	endgenerate

	// trip zones
	assign trip_w = ~{trip_zone_three, trip_zone_two, trip_zone_one};

	always_comb begin
		for (int z = 0; z < NZONE; z++) begin
			case (pwt_tzmode_e'(ctrl_r[CTRL_TZMODE + 2*z +: 2]))
				TZ_ONESHOT: begin
					// set wins over the software clear
					osht_nxt[z] = trip_w[z] | (osht_r[z] & ~osht_clr_w[z]);
					cbc_nxt[z] = 1'b0;
				end
				TZ_CBC: begin
					osht_nxt[z] = 1'b0;
					cbc_nxt[z] = trip_w[z] | (cbc_r[z] & ~und_w[0]);
				end
				default: begin
					osht_nxt[z] = 1'b0;
					cbc_nxt[z] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osht_r <= '0;
			cbc_r <= '0;
		end else begin
			osht_r <= osht_nxt;
			cbc_r <= cbc_nxt;
		end
	end

	// power stage
	always_comb begin
		ps_nxt = ps_r;
		case (ps_r)
			PS_OFF: if (ps_enable_in & ~ena_prev_r) ps_nxt = PS_ON;
			PS_ON: if (~ps_enable_in & ena_prev_r) ps_nxt = PS_OFF;
			default: ps_nxt = PS_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_r <= PS_OFF;
			ena_prev_r <= 1'b0;
			ps_enabled <= 1'b0;
			ps_enable_n <= 1'b1;
		end else begin
			ps_r <= ps_nxt;
			ena_prev_r <= ps_enable_in;
			ps_enabled <= (ps_nxt == PS_ON);
			ps_enable_n <= ~(ps_nxt == PS_ON);
		end
	end

	// trigger dividers on channel zero events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_cnt_r <= '0;
			adc_soc <= 1'b0;
		end else begin
			adc_soc <= 1'b0;
			if (ev_hit(ctrl_r[CTRL_ADCSEL +: 2], und_w[0], ovf_w[0])) begin
				if (adc_cnt_r + DIV_ONE >= adc_div_r) begin
					adc_cnt_r <= '0;
					adc_soc <= 1'b1;
				end else begin
					adc_cnt_r <= adc_cnt_r + DIV_ONE;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			task_cnt_r <= '0;
			task_trig <= 1'b0;
		end else begin
			task_trig <= 1'b0;
			if (ev_hit(ctrl_r[CTRL_TASKSEL +: 2], und_w[0], ovf_w[0])) begin
				if (task_cnt_r + DIV_ONE >= task_div_r) begin
					task_cnt_r <= '0;
					task_trig <= 1'b1;
				end else begin
					task_cnt_r <= task_cnt_r + DIV_ONE;
				end
			end
		end
	end

endmodule

/* tb/pwt_monitor.sv */
// checker of the trip-protected pwm top, sees top-level ports only
// assumes the bind below attaches it to every pwt_top instance
module pwt_monitor import pwt_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb answer
	input wire logic pready,
	input wire logic pslverr,
	// power stage
	input wire logic ps_enable_in,
	input wire logic ps_enabled,
	input wire logic ps_enable_n,
	// pwm pins
	input wire logic [NCH-1:0] pwm_out_primary,
	input wire logic [NCH-1:0] pwm_out_primary_oe,
	input wire logic [NCH-1:0] pwm_out_complement,
	input wire logic [NCH-1:0] pwm_out_complement_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_no_overlap;
		(pwm_out_primary & pwm_out_complement) == '0;
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("both outputs of a pair high");
	property p_oe_pair;
		pwm_out_primary_oe == pwm_out_complement_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair)
		else $error("pair enables differ");
	property p_en_pin;
		ps_enable_n == !ps_enabled;
	endproperty
	a_en_pin: assert property (p_en_pin)
		else $error("enable pin not inverse of status");
	property p_on;
		$rose(ps_enable_in) |=> ps_enabled;
	endproperty
	a_on: assert property (p_on)
		else $error("stage not on after enable rise");
	property p_off;
		$fell(ps_enable_in) |=> !ps_enabled;
	endproperty
	a_off: assert property (p_off)
		else $error("stage not off after enable fall");
	property p_hold;
		$stable(ps_enable_in) |=> $stable(ps_enabled);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stage changed without enable edge");
	property p_safe;
		!ps_enabled |-> (pwm_out_primary | pwm_out_complement) == '0;
	endproperty
	a_safe: assert property (p_safe)
		else $error("output high while stage off");
	property p_ready;
		pready |=> !pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready longer than one cycle");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err)
		else $error("error without ready");
	c_on: cover property ($rose(ps_enabled));
	c_trip: cover property (ps_enabled && pwm_out_primary_oe != '1);
	c_err: cover property (pslverr);
endmodule

bind pwt_top pwt_monitor u_mon (.pclk(pclk), .presetn(presetn), .pready(pready),
	.pslverr(pslverr), .ps_enable_in(ps_enable_in), .ps_enabled(ps_enabled),
	.ps_enable_n(ps_enable_n), .pwm_out_primary(pwm_out_primary),
	.pwm_out_primary_oe(pwm_out_primary_oe), .pwm_out_complement(pwm_out_complement),
	.pwm_out_complement_oe(pwm_out_complement_oe));

/* tb/pwt_stage_model.sv */
// power stage model: gate nodes behind the pwm pins, fault and enable sources
// assumes commands from the bench change right after a rising pclk edge
module pwt_stage_model import pwt_pkg::*; (
	// clock
	input wire logic pclk,
	// pwm pins
	input wire logic [NCH-1:0] pwm_out_primary,
	input wire logic [NCH-1:0] pwm_out_primary_oe,
	input wire logic [NCH-1:0] pwm_out_complement,
	input wire logic [NCH-1:0] pwm_out_complement_oe,
	// commands
	input wire logic [NZONE-1:0] fault_cmd,
	input wire logic stage_on_cmd,
	// towards the device
	output logic trip_zone_one,
	output logic trip_zone_two,
	output logic trip_zone_three,
	output logic ps_enable_in,
	// gate levels
	output logic [NCH-1:0] gate_hi,
	output logic [NCH-1:0] gate_lo
);
	logic [NCH-1:0] last_hi;
	logic [NCH-1:0] last_lo;
	// a fault pulls its zone line low
	assign trip_zone_one = !fault_cmd[0];
	assign trip_zone_two = !fault_cmd[1];
	assign trip_zone_three = !fault_cmd[2];
	assign ps_enable_in = stage_on_cmd;
	// a released gate node keeps no level: it flips every cycle
	always_ff @(posedge pclk) begin
		last_hi <= gate_hi;
		last_lo <= gate_lo;
	end
	for (genvar i = 0; i < NCH; i++) begin : g_gate
		assign gate_hi[i] = pwm_out_primary_oe[i] ? pwm_out_primary[i] : ~last_hi[i];
		assign gate_lo[i] = pwm_out_complement_oe[i] ? pwm_out_complement[i] : ~last_lo[i];
	end
endmodule

/* tb/pwt_top_bench.sv */
// self-checking bench of pwt_top over apb with a power stage model
// assumes the monitor is bound through its own file
module pwt_top_bench import pwt_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic tz1, tz2, tz3, ps_enable_in, ps_enabled, ps_enable_n;
	logic sync_in, ext_sync_pin, sync_out, adc_soc, task_trig, stage_on_cmd;
	logic [NCH-1:0] p_a, p_a_oe, p_b, p_b_oe, gate_hi, gate_lo;
	logic [NZONE-1:0] fault_cmd;
	int n_fail = 0;
	int total_checks = 0;
	pwt_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trip_zone_one(tz1), .trip_zone_two(tz2), .trip_zone_three(tz3),
		.ps_enable_in(ps_enable_in), .ps_enabled(ps_enabled), .ps_enable_n(ps_enable_n),
		.sync_in(sync_in), .ext_sync_pin(ext_sync_pin), .sync_out(sync_out),
		.adc_soc(adc_soc), .task_trig(task_trig), .pwm_out_primary(p_a),
		.pwm_out_primary_oe(p_a_oe), .pwm_out_complement(p_b), .pwm_out_complement_oe(p_b_oe));
	pwt_stage_model u_stage (.pclk(pclk), .pwm_out_primary(p_a), .pwm_out_primary_oe(p_a_oe),
		.pwm_out_complement(p_b), .pwm_out_complement_oe(p_b_oe), .fault_cmd(fault_cmd),
		.stage_on_cmd(stage_on_cmd), .trip_zone_one(tz1), .trip_zone_two(tz2),
		.trip_zone_three(tz3), .ps_enable_in(ps_enable_in), .gate_hi(gate_hi),
		.gate_lo(gate_lo));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		xfer(1'b0, a, 32'h0, q, e);
		chk(q & m, x);
	endtask
	function automatic logic probe(input int s);
		case (s)
			0: probe = adc_soc;
			1: probe = task_trig;
			2: probe = sync_out;
			3: probe = p_a[0];
			4: probe = p_b[0];
			default: probe = p_a[1];
		endcase
	endfunction
	// counts cycles with the probed signal high
	task automatic tally(input int s, input int cyc, input logic [31:0] x);
		logic [31:0] k;
		k = 32'h0;
		repeat (cyc) begin
			@(negedge pclk);
			k = k + 32'(probe(s));
		end
		chk(k, x);
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		n_fail++;
		finish_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{sync_in, ext_sync_pin, stage_on_cmd, fault_cmd} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_CTRL, 32'hffffffff, 32'h2);
		rd(ADDR_PERIOD, 32'hffffffff, 32'h3e8);
		rd(ADDR_DIV, 32'hffffffff, 32'h101);
		xfer(1'b0, 8'hfc, 32'h0, q, e);
		chk(q | {31'h0, e}, 32'h1);
		wr(ADDR_PERIOD, 32'h8);
		wr(ADDR_MOD0, 32'h4);
		wr(ADDR_MOD0 + 8'h08, 32'h9);
		tally(3, 16, 32'h0);
		@(posedge pclk);
		stage_on_cmd <= 1'b1;
		repeat (2) @(posedge pclk);
		tally(3, 16, 32'h8);
		tally(4, 16, 32'h8);
		chk({p_a[2:1], p_b[2:1], gate_hi[2], gate_lo[1]}, 32'h27);
		wr(ADDR_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		tally(3, 8, 32'h4);
		chk({p_a[2:1], p_b[2:1], ps_enabled, ps_enable_n}, 32'h1a);
		wr(ADDR_CTRL, 32'h1a2);
		wr(ADDR_DEADBAND, 32'h2);
		repeat (8) @(posedge pclk);
		tally(3, 16, 32'h4);
		tally(4, 16, 32'h4);
		wr(ADDR_DIV, 32'h0302);
		repeat (8) @(posedge pclk);
		tally(0, 48, 32'h3);
		tally(1, 48, 32'h4);
		tally(2, 32, 32'h4);
		wr(ADDR_DIV, 32'h0101);
		wr(ADDR_CTRL, 32'h53);
		repeat (8) @(posedge pclk);
		tally(0, 64, 32'h4);
		tally(2, 32, 32'h0);
		wr(ADDR_PHASE0, 32'h2);
		ext_sync_pin <= 1'b1;
		tally(2, 4, 32'h1);
		rd(ADDR_STATUS, 32'hffff0000, 32'h00060000);
		wr(ADDR_CTRL, 32'h4b);
		sync_in <= 1'b1;
		@(posedge pclk);
		sync_in <= 1'b0;
		tally(2, 4, 32'h1);
		wr(ADDR_CTRL, 32'h1202);
		wr(ADDR_DEADBAND, 32'h0);
		wr(ADDR_MOD0 + 8'h04, 32'h4);
		wr(ADDR_ZONEMAP, 32'h15);
		fault_cmd <= 3'b001;
		@(posedge pclk);
		fault_cmd <= 3'b000;
		tally(3, 16, 32'h0);
		chk({p_a[2], 31'h0}, 32'h80000000);
		rd(ADDR_STATUS, 32'h7f, 32'h41);
		wr(ADDR_STATUS, 32'h1);
		tally(3, 16, 32'h8);
		@(posedge pclk);
		fault_cmd <= 3'b010;
		@(posedge pclk);
		tally(5, 16, 32'h0);
		rd(ADDR_STATUS, 32'h7f, 32'h50);
		fault_cmd <= 3'b100;
		repeat (12) @(posedge pclk);
		tally(5, 16, 32'h8);
		tally(3, 16, 32'h8);
		rd(ADDR_STATUS, 32'h7f, 32'h40);
		fault_cmd <= 3'b000;
		wr(ADDR_CTRL, 32'h1206);
		fault_cmd <= 3'b001;
		@(posedge pclk);
		fault_cmd <= 3'b000;
		tally(4, 4, 32'h0);
		chk({p_a_oe, p_b_oe}, 32'h36);
		q[0] = gate_hi[0];
		@(negedge pclk);
		chk({31'h0, gate_hi[0] ^ q[0]}, 32'h1);
		@(posedge pclk);
		stage_on_cmd <= 1'b0;
		tally(4, 4, 32'h0);
		chk({p_a_oe, p_b_oe, ps_enabled, ps_enable_n}, 32'h1);
		finish_test();
	end
endmodule
